// ==== drg_pkg.sv ====
// Purpose: shared constants and types for the readout, gear-down and power-save block
// Assumes: one 25 MHz clock, commands already decoded to one-cycle strobes
// Notes: readout page and location codes follow the bank-address encoding
package drg_pkg;
  localparam int CLK_MHZ = 25;
  localparam logic [1:0] PAGE_MRS = 2'h2;
  localparam logic [1:0] PAGE_VENDOR = 2'h3;
  localparam logic [1:0] LOC0 = 2'h0;
  localparam logic [1:0] LOC1 = 2'h1;
  localparam logic [1:0] LOC2 = 2'h2;
  localparam logic [1:0] LOC3 = 2'h3;
  localparam int TEMP_LSB = 3;
  localparam logic [1:0] TEMP_RESET = 2'h1;
  // temperature status age limit
  localparam int TEMP_MAX_AGE_MS = 32;
  localparam int TEMP_UPDATE_CYCLES = TEMP_MAX_AGE_MS * 1000 * CLK_MHZ / 2;
  localparam int MR3_TEMP_EN_BIT = 5;
  localparam int MR4_ABORT_BIT = 9;
  localparam int MR4_MPSM_BIT = 1;
  localparam int MR3_GEAR_BIT = 3;
  localparam int GEAR_CMD_DELAY_DEF = 2;
  localparam int SR_EXIT_DELAY_DEF = 20;
  localparam int SR_ABORT_DELAY_DEF = 10;
  localparam int PS_ENTRY_DELAY_DEF = 16;
  localparam int PS_EXIT_DELAY_DEF = 32;
  localparam int CNT_W = 24;
  typedef enum logic [2:0] {
    DRG_GEAR_1N, DRG_GEAR_WAIT_SYNC, DRG_GEAR_WAIT_CMD, DRG_GEAR_2N
  } drg_gear_t;
  typedef enum logic [2:0] {
    DRG_PS_OFF, DRG_PS_ENTRY, DRG_PS_ON, DRG_PS_EXIT
  } drg_ps_t;
  // mode register image the readout page mirrors
  typedef struct packed {
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic [15:0] mr3;
    logic [15:0] mr4;
    logic [15:0] mr5;
    logic [15:0] mr6;
  } drg_mr_t;
  // decoded command strobes
  typedef struct packed {
    logic mrs_gear;
    logic sync_nop;
    logic mrs_ps;
    logic sr_enter;
    logic sr_exit;
    logic read;
  } drg_cmd_t;
endpackage

// ==== drg_temp.sv ====
// Purpose: temperature refresh status tracker
// Assumes: sensor code arrives as a two-bit level
// Notes: refresh is periodic, so while enabled data is never older than half the age limit
module drg_temp
  import drg_pkg::*;
#(
  parameter int UPDATE_CYCLES = TEMP_UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [1:0] sensor,
  output logic [1:0] status
);
  logic [CNT_W-1:0] tick;
  // free running update timer, restarted whenever updates are frozen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= '0;
    end else if (!enable || tick == CNT_W'(UPDATE_CYCLES - 1)) begin
      tick <= '0;
    end else begin
      tick <= tick + CNT_W'(1);
    end
  end
  // sample on enable edge and every period; frozen while disabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= TEMP_RESET;
    end else if (enable && tick == '0) begin
      status <= (sensor == 2'h3) ? 2'h2 : sensor;
    end
  end
endmodule

// ==== drg_top.sv ====
// What this block does
// - temperature refresh code sits in page 2 location 0 bits 4:3
// - with mode register 3 bit 5 set, status refreshed within 32 ms
// - with mode register 3 bit 5 clear, status is frozen
// - page 2 reads back mode register fields, read only
// - page 3 bit 0 reads 1,1,1,0 across locations, read only
// - after reset the device samples controls every clock (1N)
// - gear command delay after sync, device switches to 2N aligned to sync
// - 1N needs neither gear command nor sync pulse
// - self refresh and power saving drop the device back to 1N
// - self refresh exit delay uses abort delay when mode register 4 bit 9 set
// - in power saving all commands except exit and reset are ignored
// - power saving entered by the mode register command strobe
// - after entry delay only chip select, clock enable, reset matter
// - clock enable rising with chip select low starts exit
// - leaving power saving clears mode register 4 bit 1
// Purpose: readout pages 2 and 3, gear-down control and power-save entry
// Assumes: command decode lives upstream; mode registers written here as images
// Notes: delays are clock counts, parameters so benches can shorten them
module drg_top
  import drg_pkg::*;
#(
  parameter int GEAR_CMD_DELAY = GEAR_CMD_DELAY_DEF,
  parameter int SR_EXIT_DELAY = SR_EXIT_DELAY_DEF,
  parameter int SR_ABORT_DELAY = SR_ABORT_DELAY_DEF,
  parameter int PS_ENTRY_DELAY = PS_ENTRY_DELAY_DEF,
  parameter int PS_EXIT_DELAY = PS_EXIT_DELAY_DEF,
  parameter int TEMP_CYCLES = TEMP_UPDATE_CYCLES
) (
  input wire logic SYS_CLK_IN, // device clock
  input wire logic RST_N_IN, // async reset, active low
  input wire drg_cmd_t CMD_IN, // decoded command strobes
  input wire logic MR_WE_IN, // mode register write strobe
  input wire logic [2:0] MR_SEL_IN, // mode register number
  input wire logic [15:0] MR_DATA_IN, // mode register write data
  input wire logic CS_N_IN, // chip select, active low
  input wire logic CKE_IN, // clock enable
  input wire logic [1:0] RD_PAGE_IN, // readout page
  input wire logic [1:0] RD_LOC_IN, // readout location
  input wire logic [1:0] TEMP_SENSOR_IN, // sensor refresh range code
  output logic [7:0] RD_DATA_OUT, // readout data
  output logic RD_VALID_OUT, // readout data valid pulse
  output logic GEAR_2N_OUT, // device samples in 2N
  output logic CMD_READY_OUT, // commands are accepted
  output logic PS_ACTIVE_OUT, // max power saving is in force
  output logic [15:0] MR4_OUT // mode register 4 image
);
  drg_mr_t mr;
  drg_gear_t gear, next_gear;
  drg_ps_t ps, next_ps;
  logic [CNT_W-1:0] gear_cnt;
  logic [CNT_W-1:0] ps_cnt;
  logic [CNT_W-1:0] sr_cnt;
  logic in_sr;
  logic cke_d;
  logic [1:0] temp_status;
  logic cmd_gate;
  logic ps_exit_req;
  logic [7:0] next_rd;

  // one field of a mode register image
  function automatic logic pick(input logic [15:0] r, input int b);
    pick = r[b];
  endfunction

  // commands are ignored during power saving and exit delays
  assign cmd_gate = (ps == DRG_PS_OFF) && (sr_cnt == '0);
  assign CMD_READY_OUT = cmd_gate;
  // exit only on clock enable rising with chip select low
  assign ps_exit_req = CKE_IN && !cke_d && !CS_N_IN;

  // mode register images; power-save bit cleared on exit
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mr <= '0;
    end else if (ps == DRG_PS_EXIT && ps_cnt == '0) begin
      mr.mr4[MR4_MPSM_BIT] <= 1'b0;
    end else if (MR_WE_IN && cmd_gate) begin
      case (MR_SEL_IN)
        3'h0: mr.mr0 <= MR_DATA_IN;
        3'h1: mr.mr1 <= MR_DATA_IN;
        3'h2: mr.mr2 <= MR_DATA_IN;
        3'h3: mr.mr3 <= MR_DATA_IN;
        3'h4: mr.mr4 <= MR_DATA_IN;
        3'h5: mr.mr5 <= MR_DATA_IN;
        3'h6: mr.mr6 <= MR_DATA_IN;
        default: mr.mr0 <= mr.mr0;
      endcase
    end
  end
  assign MR4_OUT = mr.mr4;

  // temperature tracker, frozen when mode register 3 bit 5 is clear
  drg_temp #(
    .UPDATE_CYCLES(TEMP_CYCLES)
  ) u_temp (
    .clk(SYS_CLK_IN),
    .rst_n(RST_N_IN),
    .enable(pick(mr.mr3, MR3_TEMP_EN_BIT)),
    .sensor(TEMP_SENSOR_IN),
    .status(temp_status)
  );

  // readout mux; unused bits are zero for a deterministic answer
  always_comb begin
    next_rd = 8'h00;
    if (RD_PAGE_IN == PAGE_MRS) begin
      case (RD_LOC_IN)
        LOC0: next_rd = {3'h0, temp_status, mr.mr2[12], mr.mr2[10:9]};
        LOC1: next_rd = {mr.mr6[6:0], mr.mr3[MR3_GEAR_BIT]};
        LOC2: next_rd = {mr.mr0[6:4], mr.mr0[2], 1'b0, mr.mr2[5:3]};
        LOC3: next_rd = {mr.mr1[10:8], mr.mr5[8:6], mr.mr1[2:1]};
        default: next_rd = 8'h00;
      endcase
    end else if (RD_PAGE_IN == PAGE_VENDOR) begin
      next_rd = {7'h00, RD_LOC_IN != LOC3};
    end
  end

  // readout register; pages are read only, no write path exists
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RD_DATA_OUT <= 8'h00;
      RD_VALID_OUT <= 1'b0;
    end else begin
      RD_VALID_OUT <= CMD_IN.read && cmd_gate;
      if (CMD_IN.read && cmd_gate) begin
        RD_DATA_OUT <= next_rd;
      end
    end
  end

  // clock enable history for edge detection; resets high, the idle level of the pin,
  // so leaving reset with clock enable high never looks like a rising edge
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cke_d <= 1'b1;
    end else begin
      cke_d <= CKE_IN;
    end
  end

  // self refresh tracking and exit delay chosen by mode register 4 bit 9
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      in_sr <= 1'b0;
      sr_cnt <= '0;
    end else if (CMD_IN.sr_enter && cmd_gate) begin
      in_sr <= 1'b1;
    end else if (CMD_IN.sr_exit && in_sr) begin
      in_sr <= 1'b0;
      sr_cnt <= pick(mr.mr4, MR4_ABORT_BIT) ? CNT_W'(SR_ABORT_DELAY)
                                              : CNT_W'(SR_EXIT_DELAY);
    end else if (sr_cnt != '0) begin
      sr_cnt <= sr_cnt - CNT_W'(1);
    end
  end

  // gear-down sequencer: 1N default, gear command, sync, delay, 2N
  always_comb begin
    next_gear = gear;
    case (gear)
      DRG_GEAR_1N: begin
        if (CMD_IN.mrs_gear && cmd_gate) next_gear = DRG_GEAR_WAIT_SYNC;
      end
      DRG_GEAR_WAIT_SYNC: begin
        if (CMD_IN.sync_nop) next_gear = DRG_GEAR_WAIT_CMD;
      end
      DRG_GEAR_WAIT_CMD: begin
        if (gear_cnt == '0) next_gear = DRG_GEAR_2N;
      end
      DRG_GEAR_2N: next_gear = DRG_GEAR_2N;
      default: next_gear = DRG_GEAR_1N;
    endcase
    if (in_sr || ps != DRG_PS_OFF) next_gear = DRG_GEAR_1N;
  end

  // state and countdown of the gear sequencer
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gear <= DRG_GEAR_1N;
      gear_cnt <= '0;
    end else begin
      gear <= next_gear;
      if (gear == DRG_GEAR_WAIT_SYNC && CMD_IN.sync_nop) begin
        gear_cnt <= CNT_W'(GEAR_CMD_DELAY - 1);
      end else if (gear_cnt != '0) begin
        gear_cnt <= gear_cnt - CNT_W'(1);
      end
    end
  end
  assign GEAR_2N_OUT = (gear == DRG_GEAR_2N);

  // power saving: entry on mode register command, exit on cke edge
  always_comb begin
    next_ps = ps;
    case (ps)
      DRG_PS_OFF: begin
        if (CMD_IN.mrs_ps && cmd_gate) next_ps = DRG_PS_ENTRY;
      end
      DRG_PS_ENTRY: begin
        if (ps_cnt == '0) next_ps = DRG_PS_ON;
      end
      DRG_PS_ON: begin
        if (ps_exit_req) next_ps = DRG_PS_EXIT;
      end
      DRG_PS_EXIT: begin
        if (ps_cnt == '0) next_ps = DRG_PS_OFF;
      end
      default: next_ps = DRG_PS_OFF;
    endcase
  end

  // power saving state and its entry and exit countdowns
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ps <= DRG_PS_OFF;
      ps_cnt <= '0;
    end else begin
      ps <= next_ps;
      if (ps == DRG_PS_OFF && next_ps == DRG_PS_ENTRY) begin
        ps_cnt <= CNT_W'(PS_ENTRY_DELAY - 1);
      end else if (ps == DRG_PS_ON && next_ps == DRG_PS_EXIT) begin
        ps_cnt <= CNT_W'(PS_EXIT_DELAY - 1);
      end else if (ps_cnt != '0) begin
        ps_cnt <= ps_cnt - CNT_W'(1);
      end
    end
  end
  // only the settled mode counts as active; exit delay still blocks commands
  assign PS_ACTIVE_OUT = (ps == DRG_PS_ON);
endmodule

// ==== drg_ctrl_model.sv ====
// Purpose: controller model that issues decoded command strobes
// Assumes: one strobe per command, deselect (cs high) between them
// Notes: the clock comes from the bench and never stops
module drg_ctrl_model
  import drg_pkg::*;
(
  input wire logic clk_in, // device clock
  output drg_cmd_t cmd_out, // command strobes
  output logic cs_n_out, // chip select, active low
  output logic cke_out // clock enable
);
  initial begin
    cmd_out = 6'h00;
    cs_n_out = 1'b1;
    cke_out = 1'b1;
  end
  // one selected cycle, then only deselects follow
  task automatic issue(input drg_cmd_t c);
    @(posedge clk_in);
    cmd_out <= c;
    cs_n_out <= 1'b0;
    @(posedge clk_in);
    cmd_out <= 6'h00;
    cs_n_out <= 1'b1;
  endtask
  // gear command, then sync two clocks later, an even gap
  task automatic gear_on();
    issue(6'h20);
    issue(6'h10);
  endtask
  // clock enable low then high; chip select level picks exit or stay
  task automatic wake(input logic cs);
    @(posedge clk_in);
    cke_out <= 1'b0;
    cs_n_out <= cs;
    @(posedge clk_in);
    cke_out <= 1'b1;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
  endtask
endmodule

// ==== drg_sva.sv ====
// Purpose: port checks for readout, gear-down and power save
// Assumes: one clock, asynchronous reset active low
// Notes: delays come from the bound instance
module drg_chk
  import drg_pkg::*;
#(
  parameter int GEAR_CMD_DELAY = 2,
  parameter int PS_ENTRY_DELAY = 4,
  parameter int PS_EXIT_DELAY = 6
) (
  input wire logic SYS_CLK_IN, // clock
  input wire logic RST_N_IN, // reset, active low
  input wire drg_cmd_t CMD_IN, // strobes
  input wire logic CS_N_IN, // chip select
  input wire logic CKE_IN, // clock enable
  input wire logic RD_VALID_OUT, // read valid
  input wire logic GEAR_2N_OUT, // 2N sampling
  input wire logic CMD_READY_OUT, // commands taken
  input wire logic PS_ACTIVE_OUT, // power save
  input wire logic [15:0] MR4_OUT // mode register 4
);
  localparam int G1 = GEAR_CMD_DELAY + 1;
  localparam int ENT_MAX = PS_ENTRY_DELAY + 1;
  localparam int EXIT_MAX = PS_EXIT_DELAY + 1;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_ps_taken; CMD_IN.mrs_ps && CMD_READY_OUT; endsequence
  sequence s_wake_stay; PS_ACTIVE_OUT && $rose(CKE_IN) && CS_N_IN; endsequence
  property p_rd_ans; CMD_IN.read && CMD_READY_OUT |=> RD_VALID_OUT; endproperty
  property p_rd_cause; RD_VALID_OUT |-> $past(CMD_IN.read) && $past(CMD_READY_OUT); endproperty
  property p_gear_on; CMD_IN.sync_nop && !GEAR_2N_OUT |-> ##[1:G1] GEAR_2N_OUT; endproperty
  // 2N only ever follows a sync pulse, so reset leaves 1N
  property p_gear_cause;
    $rose(GEAR_2N_OUT) |-> $past(CMD_IN.sync_nop, GEAR_CMD_DELAY) || $past(CMD_IN.sync_nop, G1);
  endproperty
  property p_ps_entry; s_ps_taken |=> !CMD_READY_OUT ##[0:ENT_MAX] PS_ACTIVE_OUT; endproperty
  property p_ps_quiet; PS_ACTIVE_OUT |-> !CMD_READY_OUT && !GEAR_2N_OUT; endproperty
  property p_ps_stay; s_wake_stay |=> PS_ACTIVE_OUT [*2]; endproperty
  property p_ps_exit;
    $fell(PS_ACTIVE_OUT) |-> ##[0:EXIT_MAX] (CMD_READY_OUT && !MR4_OUT[MR4_MPSM_BIT]);
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rd_cause: assert property (p_rd_cause) else $error("unprompted read valid");
  a_gear_on: assert property (p_gear_on) else $error("2N late after sync");
  a_gear_cause: assert property (p_gear_cause) else $error("2N without sync");
  a_ps_entry: assert property (p_ps_entry) else $error("power save entry slow");
  a_ps_quiet: assert property (p_ps_quiet) else $error("busy in power save");
  a_ps_stay: assert property (p_ps_stay) else $error("left power save");
  a_ps_exit: assert property (p_ps_exit) else $error("exit incomplete");
endmodule

bind drg_top drg_chk #(.GEAR_CMD_DELAY(GEAR_CMD_DELAY), .PS_ENTRY_DELAY(PS_ENTRY_DELAY),
  .PS_EXIT_DELAY(PS_EXIT_DELAY)) u_chk (.SYS_CLK_IN, .RST_N_IN, .CMD_IN, .CS_N_IN,
  .CKE_IN, .RD_VALID_OUT, .GEAR_2N_OUT, .CMD_READY_OUT, .PS_ACTIVE_OUT, .MR4_OUT);

// ==== drg_top_tb.sv ====
// Purpose: self-checking bench for the readout, gear and power-save block
// Assumes: controller model issues every command strobe
// Notes: abort, power-save and temperature delays are shortened by parameters to keep the run brief
module drg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import drg_pkg::*;
  localparam int GD = GEAR_CMD_DELAY_DEF, SRX = SR_EXIT_DELAY_DEF;
  localparam int SRA = 4, PSE = 4, PSX = 6, TC = 8;
  logic clk, rst_n, mr_we, rd_valid, gear, ready, ps_act, cs_n, cke;
  logic [2:0] mr_sel;
  logic [15:0] mr_data, mr4;
  logic [1:0] page, loc, sensor;
  logic [7:0] rd_data;
  logic [15:0] mr [7];
  drg_cmd_t cmd;
  int errors, num_checks;
  drg_ctrl_model ctl (.clk_in(clk), .cmd_out(cmd), .cs_n_out(cs_n), .cke_out(cke));
  drg_top #(.SR_ABORT_DELAY(SRA),
    .PS_ENTRY_DELAY(PSE), .PS_EXIT_DELAY(PSX), .TEMP_CYCLES(TC)) dut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_IN(cmd), .MR_WE_IN(mr_we), .MR_SEL_IN(mr_sel),
    .MR_DATA_IN(mr_data), .CS_N_IN(cs_n), .CKE_IN(cke), .RD_PAGE_IN(page), .RD_LOC_IN(loc),
    .TEMP_SENSOR_IN(sensor), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
    .GEAR_2N_OUT(gear), .CMD_READY_OUT(ready), .PS_ACTIVE_OUT(ps_act), .MR4_OUT(mr4));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // expected readout from our own mode register copy; unused bits zero
  function automatic logic [7:0] p2(input logic [1:0] l, input logic [1:0] t);
    case (l)
      2'h0: return {3'h0, t, mr[2][12], mr[2][10:9]};
      2'h1: return {mr[6][6:0], mr[3][3]};
      2'h2: return {mr[0][6:4], mr[0][2], 1'b0, mr[2][5:3]};
      default: return {mr[1][10:8], mr[5][8:6], mr[1][2:1]};
    endcase
  endfunction
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    mr_we <= 1'b1;
    mr_sel <= s;
    mr_data <= d;
    mr[s] = d;
    @(posedge clk);
    mr_we <= 1'b0;
  endtask
  // read answers one cycle after the strobe, valid and data together
  task automatic rd(input logic [1:0] p, input logic [1:0] l, input logic [7:0] e);
    @(posedge clk);
    page <= p;
    loc <= l;
    ctl.issue(6'h01);
    #1 chk({7'h00, rd_valid, rd_data}, {7'h00, 1'b1, e});
  endtask
  task automatic t_regs();
    wr(0, 16'h0A54);
    wr(1, 16'h0516);
    wr(2, 16'h1638);
    wr(3, 16'h0028);
    wr(5, 16'h01C0);
    wr(6, 16'h005B);
    for (int l = 0; l < 4; l++) begin
      rd(2, l[1:0], p2(l[1:0], 2'h1));
      rd(3, l[1:0], {7'h00, l != 3});
    end
  endtask
  task automatic t_temp();
    @(posedge clk);
    sensor <= 2'h3;
    repeat (2 * TC + 4) @(posedge clk);
    rd(2, 0, p2(0, 2'h2));
    wr(3, 16'h0008);
    sensor <= 2'h0;
    repeat (2 * TC + 4) @(posedge clk);
    rd(2, 0, p2(0, 2'h2));
  endtask
  // gear entry, self refresh drops to 1N, exit delay by the abort bit
  task automatic t_gear();
    int n;
    chk(16'(gear), 16'h0000);
    for (int a = 0; a < 2; a++) begin
      ctl.gear_on();
      repeat (GD - 1) @(posedge clk);
      #1 chk(16'(gear), 16'h0000);
      @(posedge clk);
      #1 chk(16'(gear), 16'h0001);
      wr(4, a ? 16'h0200 : 16'h0000);
      ctl.issue(6'h04);
      repeat (2) @(posedge clk);
      #1 chk(16'(gear), 16'h0000);
      ctl.issue(6'h02);
      n = 0;
      #1 while (!ready && n < 100) begin
        @(posedge clk);
        #1 n++;
      end
      chk(16'(n), 16'(a ? SRA : SRX));
    end
  endtask
  task automatic t_ps();
    int n;
    wr(3, 16'h0000);
    wr(4, 16'h0002);
    ctl.issue(6'h08);
    repeat (PSE + 2) @(posedge clk);
    #1 chk(16'({ps_act, ready}), 16'h0002);
    ctl.issue(6'h01);
    #1 chk(16'(rd_valid), 16'h0000);
    ctl.wake(1'b1);
    repeat (2) @(posedge clk);
    #1 chk(16'(ps_act), 16'h0001);
    ctl.wake(1'b0);
    n = 0;
    #1 while (!ready && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'({ps_act, mr4[1], n < 100}), 16'h0001);
    chk(16'(n), 16'(PSX));
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    mr_we = 1'b0;
    mr_sel = 3'h0;
    mr_data = 16'h0000;
    page = 2'h0;
    loc = 2'h0;
    sensor = 2'h1;
    mr = '{default: 16'h0000};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_temp();
    t_gear();
    t_ps();
    final_report();
  end
endmodule
